// >>> doorbell_map.vh
// Purpose: constants for the shared-memory doorbell and board reset logic
// Assumes: 25 MHz board clock
// Notes:   times are in microseconds, counts derived from them
`ifndef DOORBELL_MAP_VH
`define DOORBELL_MAP_VH
`define DB_ADDR_W        10
`define DB_DATA_W        8
`define DB_DEPTH         1024
`define DB_DOOR_ADDR     10'h000
`define DB_BIT_RING      0
`define DB_BIT_RESET     1
`define DB_CLK_MHZ       25
`define DB_RST_MIN_US    2000
`define DB_RST_MAX_US    4000
`define DB_RST_CYCLES    ((`DB_RST_MIN_US * `DB_CLK_MHZ + `DB_RST_MAX_US * `DB_CLK_MHZ) / 2)
`define DB_CNT_W         17
`define DB_CODE_CLEAR    2'h0
`define DB_CODE_RING     2'h1
`define DB_CODE_RESET    2'h2
`define DB_ONIRQ_IDLE    8'h00
`define DB_BUSIRQ_IDLE   8'hFF
`endif

// >>> doorbell_dpram.v
// Purpose: dual-port RAM with doorbell interrupts and a program-controlled board reset
// Assumes: both ports synchronous to mclk; one write per port per cycle
// Notes:   location 0 codes act only on writes; reads are plain memory
// Operation
// [R01] bus-side write of 01H to location 0 raises the on-board request
// [R02] on-board request holds until on-board write of 00H to location 0
// [R03] reads of location 0 return stored data and leave both requests alone
// [R04] on-board write of 01H to location 0 raises the system-bus request
// [R05] bus request holds until a bus-side write of 00H to location 0
// [R06] each request is steered to one of eight lines by static select
// [R07] bus-side write of 02H to location 0 resets board when enabled
// [R08] default reset is one pulse between two and four milliseconds long
// [R09] extended reset holds until a bus-side write of 00H to location 0
// [R10] memory keeps serving both ports while the board reset is active
// [R11] a static enable gates the program-controlled reset
// [R12] other locations never touch requests or reset; location 0 stores all writes
`include "doorbell_map.vh"
module doorbell_dpram
  #(
    parameter RST_CYCLES = `DB_RST_CYCLES
  )
  (
    input  wire                    mclk,
    input  wire                    srst,
    input  wire                    cpuWe,
    input  wire                    cpuRe,
    input  wire [`DB_ADDR_W-1:0]   cpuAddr,
    input  wire [`DB_DATA_W-1:0]   cpuWdata,
    output reg  [`DB_DATA_W-1:0]   cpuRdata,
    input  wire                    busWe,
    input  wire                    busRe,
    input  wire [`DB_ADDR_W-1:0]   busAddr,
    input  wire [`DB_DATA_W-1:0]   busWdata,
    output reg  [`DB_DATA_W-1:0]   busRdata,
    input  wire [2:0]              onboardIrqSel,
    input  wire [2:0]              busIrqSel,
    input  wire                    resetEnable,
    input  wire                    resetExtended,
    output reg  [7:0]              onboardIrq,
    output reg  [7:0]              busIrqN,
    output reg                     boardReset
  );

  // one array serves both ports; location 0 is also the doorbell word
  reg [`DB_DATA_W-1:0] mem [0:`DB_DEPTH-1];

  reg                  onboardReq_reg;
  reg                  onboardReq_next;
  reg                  busReq_reg;
  reg                  busReq_next;
  reg                  rstActive_reg;
  reg                  rstActive_next;
  reg [`DB_CNT_W-1:0]  rstCnt_reg;
  reg [`DB_CNT_W-1:0]  rstCnt_next;
  reg [7:0]            onboardLines_next;
  reg [7:0]            busLinesN_next;
  reg                  rstStart;
  reg                  rstStop;
  reg                  rstStep;

  localparam [31:0]          RST_LAST_FULL = RST_CYCLES - 1;
  localparam [`DB_CNT_W-1:0] RST_LAST      = RST_LAST_FULL[`DB_CNT_W-1:0];
  localparam [`DB_CNT_W-1:0] CNT_ZERO      = {`DB_CNT_W{1'b0}};
  localparam [`DB_CNT_W-1:0] CNT_ONE       = {{(`DB_CNT_W-1){1'b0}}, 1'b1};

  // only bits 1:0 carry the code; upper data bits are plain memory
  function [1:0] codeOf;
    input [`DB_DATA_W-1:0] data;
    begin
      codeOf = {data[`DB_BIT_RESET], data[`DB_BIT_RING]};
    end
  endfunction

  function isDoor;
    input                  we;
    input [`DB_ADDR_W-1:0] addr;
    begin
      isDoor = we && (addr == `DB_DOOR_ADDR);
    end
  endfunction

  // code test on a location-0 write: ring = 01, clear = 00, reset = 10
  function isCode;
    input                   we;
    input [`DB_ADDR_W-1:0]  addr;
    input [`DB_DATA_W-1:0]  data;
    input [1:0]             code;
    begin
      isCode = isDoor(we, addr) && (codeOf(data) == code);
    end
  endfunction

  // one-hot line select shared by both request routes
  function [7:0] lineSelect;
    input       req;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    lineSelect = 8'h01;
        3'h1:    lineSelect = 8'h02;
        3'h2:    lineSelect = 8'h04;
        3'h3:    lineSelect = 8'h08;
        3'h4:    lineSelect = 8'h10;
        3'h5:    lineSelect = 8'h20;
        3'h6:    lineSelect = 8'h40;
        default: lineSelect = 8'h80;
      endcase
      if (!req)
        lineSelect = 8'h00;
    end
  endfunction

  wire busRing  = isCode(busWe, busAddr, busWdata, `DB_CODE_RING);
  wire busClear = isCode(busWe, busAddr, busWdata, `DB_CODE_CLEAR);
  wire busRst   = isCode(busWe, busAddr, busWdata, `DB_CODE_RESET);
  wire cpuRing  = isCode(cpuWe, cpuAddr, cpuWdata, `DB_CODE_RING);
  wire cpuClear = isCode(cpuWe, cpuAddr, cpuWdata, `DB_CODE_CLEAR);

  // memory ignores srst and board reset so both ports keep working
  // same-address writes in one cycle: bus side wins, being written last
  always @(posedge mclk)
  begin
    if (cpuWe)
    begin
      mem[cpuAddr] <= cpuWdata; // [R12]
    end
    if (busWe)
    begin
      mem[busAddr] <= busWdata; // [R12] [R10]
    end
  end

  always @(posedge mclk)
  begin
    if (cpuRe)
    begin
      cpuRdata <= mem[cpuAddr]; // [R03]
    end
  end

  always @(posedge mclk)
  begin
    if (busRe)
    begin
      busRdata <= mem[busAddr]; // [R03] [R10]
    end
  end

  // ring beats clear when both sides hit location 0 in one cycle
  always @*
  begin
    onboardReq_next = onboardReq_reg;
    if (busRing)
    begin
      onboardReq_next = 1'b1; // [R01]
    end
    else if (cpuClear)
    begin
      onboardReq_next = 1'b0; // [R02]
    end
  end

  always @*
  begin
    busReq_next = busReq_reg;
    if (cpuRing)
    begin
      busReq_next = 1'b1; // [R04]
    end
    else if (busClear)
    begin
      busReq_next = 1'b0; // [R05]
    end
  end

  // a fresh reset code restarts the count; 00H never shortens a pulse
  always @*
  begin
    rstStart = busRst && resetEnable; // [R07] [R11]
    rstStop  = 1'b0;
    rstStep  = 1'b0;
    if (rstActive_reg && !rstStart)
    begin
      if (resetExtended)
      begin
        rstStop = busClear; // [R09]
      end
      else if (rstCnt_reg == RST_LAST)
      begin
        rstStop = 1'b1; // [R08]
      end
      else
      begin
        rstStep = 1'b1; // [R08]
      end
    end
  end

  always @*
  begin
    rstActive_next = rstActive_reg;
    rstCnt_next    = rstCnt_reg;
    if (rstStart)
    begin
      rstActive_next = 1'b1;
      rstCnt_next    = CNT_ZERO;
    end
    else if (rstStop)
    begin
      rstActive_next = 1'b0;
    end
    else if (rstStep)
    begin
      rstCnt_next = rstCnt_reg + CNT_ONE;
    end
  end

  always @*
  begin
    onboardLines_next = lineSelect(onboardReq_next, onboardIrqSel); // [R06]
    busLinesN_next    = ~lineSelect(busReq_next, busIrqSel); // [R06]
  end

  // srst is the board power-on reset; the generated board reset is an output
  // only, so the requests survive it unless the system wires it back to srst
  always @(posedge mclk)
  begin
    if (srst)
    begin
      onboardReq_reg <= 1'b0;
    end
    else
    begin
      onboardReq_reg <= onboardReq_next;
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      busReq_reg <= 1'b0;
    end
    else
    begin
      busReq_reg <= busReq_next;
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      rstActive_reg <= 1'b0;
    end
    else
    begin
      rstActive_reg <= rstActive_next;
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      rstCnt_reg <= CNT_ZERO;
    end
    else
    begin
      rstCnt_reg <= rstCnt_next;
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      onboardIrq <= `DB_ONIRQ_IDLE;
    end
    else
    begin
      onboardIrq <= onboardLines_next; // [R06]
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      busIrqN <= `DB_BUSIRQ_IDLE;
    end
    else
    begin
      busIrqN <= busLinesN_next; // [R06]
    end
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      boardReset <= 1'b0;
    end
    else
    begin
      boardReset <= rstActive_next;
    end
  end

endmodule

// >>> doorbell_dpram_props.sv
// Purpose: doorbell and board reset checks
// Assumes: one clock, srst synchronous
// Notes:   code 3 stands for no action at location 0
module doorbell_dpram_props #(parameter RST_CYCLES = 20) (
  input logic       mclk, srst, cpuWe, busWe, resetEnable, resetExtended, boardReset,
  input logic [9:0] cpuAddr, busAddr,
  input logic [7:0] cpuWdata, busWdata, onboardIrq, busIrqN,
  input logic [2:0] onboardIrqSel, busIrqSel);
  wire [1:0] bc = busWe && !busAddr ? busWdata[1:0] : 2'h3;
  wire [1:0] cc = cpuWe && !cpuAddr ? cpuWdata[1:0] : 2'h3;
  logic [16:0] cnt;
  always @(posedge mclk) cnt <= srst || resetEnable && bc == 2 ? 17'h0 : cnt + boardReset;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_on_ring: assert property (bc==1 |=> onboardIrq==1<<onboardIrqSel) else $error("ring");
  chk_on_clear: assert property (cc==0 && bc!=1 |=> !onboardIrq) else $error("clear");
  chk_bus_ring: assert property (cc==1 |=> busIrqN==~(8'h01<<busIrqSel)) else $error("ring");
  chk_bus_clear: assert property (bc==0 && cc!=1 |=> &busIrqN) else $error("clear");
  chk_irq_hold: assert property (&{bc, cc} |=> $stable({onboardIrq, busIrqN})) else $error("hold");
  chk_rst_start: assert property (resetEnable && bc==2 |=> boardReset) else $error("start");
  chk_rst_pulse: assert property ($fell(boardReset) && !resetExtended |-> cnt==RST_CYCLES) else $error("len");
  chk_rst_hold: assert property (resetExtended && boardReset && bc!=0 |=> boardReset) else $error("held");
  chk_rst_gate: assert property (!resetEnable && bc==2 && !boardReset |=> !boardReset) else $error("gate");
  cover property (bc == 1); cover property (cc == 1); cover property ($fell(boardReset));
  cover property (resetExtended && boardReset && bc == 0);
endmodule
bind doorbell_dpram doorbell_dpram_props #(.RST_CYCLES(RST_CYCLES)) chk (
  .mclk(mclk), .srst(srst), .cpuWe(cpuWe), .busWe(busWe), .resetEnable(resetEnable),
  .resetExtended(resetExtended), .boardReset(boardReset), .cpuAddr(cpuAddr),
  .busAddr(busAddr), .cpuWdata(cpuWdata), .busWdata(busWdata), .onboardIrq(onboardIrq),
  .busIrqN(busIrqN), .onboardIrqSel(onboardIrqSel), .busIrqSel(busIrqSel));

// >>> bus_master_model.sv
// Purpose: system bus master sharing the memory
// Assumes: drives just after the clock edge
// Notes:   idle lines show inverted address and data after a write; after a read the address is inverted and data keeps its last value
module bus_master_model (input logic mclk, output logic busWe = 1'b0, output logic busRe = 1'b0,
  output logic [9:0] busAddr = 10'h000, output logic [7:0] busWdata = 8'h00);
  timeunit 1ns; timeprecision 1ns;
  task wr(logic [9:0] a, logic [7:0] d);
    @(posedge mclk) #1 {busWe, busAddr, busWdata} = {1'b1, a, d};
    @(posedge mclk) #1 {busWe, busAddr, busWdata} = {1'b0, ~a, ~d};
  endtask
  task rd(logic [9:0] a);
    @(posedge mclk) #1 {busRe, busAddr} = {1'b1, a};
    @(posedge mclk) #1 {busRe, busAddr} = {1'b0, ~a};
  endtask
endmodule

// >>> tb_doorbell_dpram.sv
// Purpose: doorbell and board reset bench
// Assumes: pulse length cut to 20 cycles
// Notes:   selects move only while both requests are idle
module tb_doorbell_dpram;
  timeunit 1ns; timeprecision 1ns;
  logic mclk = 0, srst = 1, cpuWe = 0, cpuRe = 0, busRe, busWe, boardReset;
  logic resetEnable = 1, resetExtended = 0, r;
  logic [9:0] cpuAddr = 10'h000, busAddr;
  logic [7:0] cpuWdata = 8'h00, cpuRdata, busRdata, busWdata, onboardIrq, busIrqN, d, n;
  logic [2:0] onboardIrqSel = 3'h0, busIrqSel = 3'h0;
  int failures = 0, checks_done = 0;
  always #20 mclk = ~mclk;
  bus_master_model M (.mclk(mclk), .busWe(busWe), .busRe(busRe), .busAddr(busAddr),
    .busWdata(busWdata));
  doorbell_dpram #(.RST_CYCLES(20)) DUT (.mclk(mclk), .srst(srst), .cpuWe(cpuWe),
    .cpuRe(cpuRe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .busWe(busWe), .busRe(busRe), .busAddr(busAddr), .busWdata(busWdata),
    .busRdata(busRdata), .onboardIrqSel(onboardIrqSel), .busIrqSel(busIrqSel),
    .resetEnable(resetEnable), .resetExtended(resetExtended), .onboardIrq(onboardIrq),
    .busIrqN(busIrqN), .boardReset(boardReset));
  task chk(string s, logic [7:0] e, g);
    checks_done++;
    failures += g !== e;
    if (g !== e) $display("[ERR] %s exp %h got %h", s, e, g);
  endtask
  task cpu(logic w, logic [9:0] a, logic [7:0] v);
    @(posedge mclk) #1 {cpuWe, cpuRe, cpuAddr, cpuWdata} = {w, !w, a, v};
    @(posedge mclk) #1 {cpuWe, cpuRe} = 2'h0;
  endtask
  task print_verdict(int lost);
    failures += lost;
    $display("checks %0d failures %0d", checks_done, failures);
    if (!failures && checks_done) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial #100000 print_verdict(1);
  initial
  begin
    void'($urandom(75852));
    repeat (12) @(posedge mclk);
    #1 srst = 0;
    repeat (4)
    begin
      {r, d, onboardIrqSel, busIrqSel} = 15'($urandom);
      M.wr({r, d, 1'b1}, 8'h01); cpu(1, {r, d, 1'b1}, 8'h01);
      chk("onIrq", 8'h00, onboardIrq);
      chk("busIrqN", 8'hFF, busIrqN);
      M.rd({r, d, 1'b1}); chk("busRdata", 8'h01, busRdata);
      M.wr(0, {d[7:2], 2'h1}); chk("onIrq", 8'h01 << onboardIrqSel, onboardIrq);
      cpu(0, 10'h000, 8'h00); chk("cpuRdata", {d[7:2], 2'h1}, cpuRdata);
      chk("onIrq", 8'h01 << onboardIrqSel, onboardIrq);
      cpu(1, 10'h000, {d[7:2], 2'h1}); chk("busIrqN", ~(8'h01 << busIrqSel), busIrqN);
      M.rd(0); chk("busRdata", {d[7:2], 2'h1}, busRdata);
      chk("busIrqN", ~(8'h01 << busIrqSel), busIrqN);
      cpu(1, 10'h000, {d[7:2], 2'h0}); chk("onIrq", 8'h00, onboardIrq);
      M.wr(0, {d[7:2], 2'h0}); chk("busIrqN", 8'hFF, busIrqN);
    end
    M.wr(0, 8'h02);
    for (n = 0; boardReset && n < 99; n++) @(posedge mclk) #1;
    chk("pulse", 8'h14, n);
    resetEnable = 0;
    M.wr(0, 8'h02); chk("boardReset", 8'h00, boardReset);
    {resetEnable, resetExtended} = 2'h3;
    M.wr(0, 8'h02);
    repeat (30) @(posedge mclk);
    cpu(0, 10'h000, 8'h00); chk("cpuRdata", 8'h02, cpuRdata);
    chk("boardReset", 8'h01, boardReset);
    M.wr(0, 8'h00); chk("boardReset", 8'h00, boardReset);
    print_verdict(0);
  end
endmodule
